// ---- rtl/rtc_alarm_core.sv ----
// Purpose: alarm compare, tick pre-scaler with external test tick,
//   reset override and two-wire slave register port of a clock device
// Assumes: all inputs synchronous to i_core_clk; i_tick_64hz is a one-cycle
//   pulse; SCL/SDA are slow against the 40 MHz clock
// Notes: one packed state, one combinational next-state, one register
`timescale 1ns/1ps
`include "rtc_alarm_map.svh"

// What this block does
// - compare alarm fields whose disable bit is zero
// - set hit flag when enabled fields first match
// - flag sticky; re-set only on new match entry
// - disabled alarm fields ignored entirely
// - alarm minute 09, alarm hour 0A layouts
// - alarm date 0B, alarm weekday 0C layouts
// - test select makes square-wave pin an input
// - test mode: pin edges replace 64 Hz tick
// - six-stage pre-scaler divides tick to seconds
// - halt bit holds pre-scaler at zero
// - first second after 32 edges, then 64
// - override sequence ends power-on reset immediately
// - writing permit zero ends override mode only
// - no override re-entry until permit is one
// - START/STOP detected with SCL high; repeated START
// - bytes are eight bits, MSB first, unlimited
// - register pointer increments after every data byte
// - transmitter releases SDA; receiver acks ninth clock
// - master no-ack ends reading; wait for STOP
// - respond only to address A2/A3 first byte
// - hit flag: write zero clears, one keeps
// - halt clears divider; square wave continues
// - override permit resets to one
module rtc_alarm_core (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // time base and oscillator start-up
  input wire logic i_tick_64hz,
  input wire logic i_osc_ready,
  input wire logic i_override_seq,
  // square-wave pin and the wave to put on it
  input wire logic i_sqw_wave,
  input wire logic i_sqw,
  output rtc_alarm_pkg::pin_drive_s o_sqw,
  // two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  output rtc_alarm_pkg::pin_drive_s o_sda,
  // status
  output logic o_por_active,
  output logic o_override_active,
  output logic o_alarm_hit,
  output logic o_external_tick_mode
);

  rtc_alarm_pkg::core_state_s state_ff;
  rtc_alarm_pkg::core_state_s nxt_state;

  // returns {carry, next bcd}
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] base);
    if (v == top)
      bcd_step = {1'b1, base};
    else if (v[3:0] == 4'h9)
      bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_step

  // one alarm field takes part only while its disable bit is clear
  function automatic logic field_ok(input logic [7:0] al, input logic [7:0] cur);
    field_ok = al[`BIT_ALARM_FIELD_DISABLE] || (al[6:0] == cur[6:0]);
  endfunction : field_ok

  function automatic logic [7:0] reg_read(input logic [7:0] a,
                                          input rtc_alarm_pkg::core_state_s s);
    reg_read = 8'h00;
    case (a)
      `OFS_CONTROL_ONE:
      begin
        reg_read[`BIT_EXT_TICK_TEST_SELECT] = s.test_sel;
        reg_read[`BIT_DIVIDER_HALT] = s.halt;
        reg_read[`BIT_OVERRIDE_PERMIT] = s.permit;
      end
      `OFS_CONTROL_STATUS_TWO:
      begin
        reg_read[`BIT_COUNTDOWN_IRQ_STYLE] = s.irq_style;
        reg_read[`BIT_ALARM_HIT_FLAG] = s.hit_flag;
        reg_read[`BIT_COUNTDOWN_FLAG] = s.cd_flag;
        reg_read[`BIT_ALARM_IRQ_ENABLE] = s.alarm_irq_enable;
        reg_read[`BIT_COUNTDOWN_IRQ_ENABLE] = s.countdown_irq_enable;
      end
      `OFS_SECONDS_COUNT: reg_read = {s.oscillator_fail_flag, s.sec};
      `OFS_MINUTES_COUNT: reg_read = {1'b0, s.min};
      `OFS_HOURS_COUNT: reg_read = {2'b00, s.hour};
      `OFS_DATE_COUNT: reg_read = {2'b00, s.date};
      `OFS_WEEKDAY_COUNT: reg_read = {5'h00, s.wday};
      `OFS_ALARM_MINUTE: reg_read = s.al_min;
      `OFS_ALARM_HOUR: reg_read = {s.al_hour[7], 1'b0, s.al_hour[5:0]};
      `OFS_ALARM_DATE: reg_read = {s.al_date[7], 1'b0, s.al_date[5:0]};
      `OFS_ALARM_WEEKDAY: reg_read = {s.al_wday[7], 4'h0, s.al_wday[2:0]};
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  logic tick;
  logic second;
  logic any_enabled;
  logic match;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic do_write;
  logic [7:0] wr_data;
  logic [8:0] step_s;
  logic [8:0] step_m;
  logic [8:0] step_h;
  logic [8:0] step_d;
  logic [7:0] rd_byte;

  always_comb
  begin
    nxt_state = state_ff;
    do_write = 1'b0;
    wr_data = state_ff.shift;
    step_s = 9'h000;
    step_m = 9'h000;
    step_h = 9'h000;
    step_d = 9'h000;
    rd_byte = reg_read(state_ff.ptr, state_ff);

    // tick source: pin edges in test mode, else the internal 64 Hz pulse
    nxt_state.sqw_q = i_sqw;
    if (state_ff.test_sel)
      tick = i_sqw && !state_ff.sqw_q;
    else
      tick = i_tick_64hz;

    // pre-scaler; halt is sampled each clock, so it clears within one cycle
    second = 1'b0;
    if (state_ff.halt)
      nxt_state.prescale = 6'h00;
    else if (tick)
    begin
      nxt_state.prescale = state_ff.prescale + 6'h01;
      // a second falls on the step to 32, so 32 edges after halt, then 64
      second = (state_ff.prescale == `PRESCALE_FIRST_STEP);
    end

    // time chain, carried just far enough to keep the compare fields moving
    if (second)
    begin
      step_s = bcd_step({1'b0, state_ff.sec}, `BCD_MAX_SECONDS, 8'h00);
      nxt_state.sec = step_s[6:0];
      if (step_s[8])
      begin
        step_m = bcd_step({1'b0, state_ff.min}, `BCD_MAX_MINUTES, 8'h00);
        nxt_state.min = step_m[6:0];
      end
      if (step_s[8] && step_m[8])
      begin
        step_h = bcd_step({2'b00, state_ff.hour}, `BCD_MAX_HOURS, 8'h00);
        nxt_state.hour = step_h[5:0];
      end
      if (step_s[8] && step_m[8] && step_h[8])
      begin
        // month length is not known here; date wraps at its widest range
        step_d = bcd_step({2'b00, state_ff.date}, `BCD_MAX_DATE, `BCD_MIN_DATE);
        nxt_state.date = step_d[5:0];
        if (state_ff.wday == `MAX_WEEKDAY)
          nxt_state.wday = 3'h0;
        else
          nxt_state.wday = state_ff.wday + 3'h1;
      end
    end

    // alarm compare; an alarm with every field disabled never fires
    any_enabled = !(state_ff.al_min[7] && state_ff.al_hour[7] &&
                    state_ff.al_date[7] && state_ff.al_wday[7]);
    match = any_enabled &&
            field_ok(state_ff.al_min, {1'b0, state_ff.min}) &&
            field_ok({state_ff.al_hour[7], 1'b0, state_ff.al_hour[5:0]},
                     {2'b00, state_ff.hour}) &&
            field_ok({state_ff.al_date[7], 1'b0, state_ff.al_date[5:0]},
                     {2'b00, state_ff.date}) &&
            field_ok({state_ff.al_wday[7], 4'h0, state_ff.al_wday[2:0]},
                     {5'h00, state_ff.wday});
    nxt_state.match_q = match;

    // power-on reset and its override
    if (i_osc_ready)
      nxt_state.por = 1'b0;
    if (i_override_seq && state_ff.permit && !state_ff.override)
    begin
      nxt_state.override = 1'b1;
      nxt_state.por = 1'b0;
    end

    // square-wave pin: input in test mode, open-drain wave otherwise
    nxt_state.square_wave_pin.out = 1'b0;
    nxt_state.square_wave_pin.oe = !nxt_state.test_sel && !i_sqw_wave;

    // two-wire bus conditions
    nxt_state.scl_q = i_scl;
    nxt_state.sda_q = i_sda;
    scl_rise = i_scl && !state_ff.scl_q;
    scl_fall = !i_scl && state_ff.scl_q;
    start_seen = i_scl && state_ff.scl_q && state_ff.sda_q && !i_sda;
    stop_seen = i_scl && state_ff.scl_q && !state_ff.sda_q && i_sda;

    if (state_ff.por || stop_seen)
    begin
      nxt_state.bus = rtc_alarm_pkg::BUS_IDLE;
      nxt_state.sda.oe = 1'b0;
    end
    else if (start_seen)
    begin
      // a start in mid-transfer is a repeated start, same handling
      nxt_state.bus = rtc_alarm_pkg::BUS_ADDR;
      nxt_state.bit_cnt = 4'h0;
      nxt_state.ptr_loaded = 1'b0;
      nxt_state.sda.oe = 1'b0;
    end
    else
    begin
      case (state_ff.bus)
        rtc_alarm_pkg::BUS_ADDR, rtc_alarm_pkg::BUS_WRITE:
        begin
          if (scl_rise && state_ff.bit_cnt < 4'h8)
          begin
            nxt_state.shift = {state_ff.shift[6:0], i_sda};
            nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
          end
          else if (scl_fall && state_ff.bit_cnt == 4'h8)
          begin
            if (state_ff.bus == rtc_alarm_pkg::BUS_ADDR)
            begin
              if (state_ff.shift[7:1] == `SLAVE_ADDR_7)
              begin
                nxt_state.reading = state_ff.shift[0];
                nxt_state.sda.oe = 1'b1;
                nxt_state.bus = rtc_alarm_pkg::BUS_ACK;
              end
              else
                nxt_state.bus = rtc_alarm_pkg::BUS_IDLE;
            end
            else
            begin
              nxt_state.sda.oe = 1'b1;
              nxt_state.bus = rtc_alarm_pkg::BUS_ACK;
              if (!state_ff.ptr_loaded)
              begin
                nxt_state.ptr = state_ff.shift;
                nxt_state.ptr_loaded = 1'b1;
              end
              else
              begin
                do_write = 1'b1;
                nxt_state.ptr = state_ff.ptr + 8'h01;
              end
            end
          end
        end
        rtc_alarm_pkg::BUS_ACK:
        begin
          if (scl_fall)
          begin
            nxt_state.bit_cnt = 4'h0;
            if (state_ff.reading)
            begin
              // read from the pointer left by earlier access
              nxt_state.shift = rd_byte;
              nxt_state.ptr = state_ff.ptr + 8'h01;
              nxt_state.sda.oe = !rd_byte[7];
              nxt_state.bus = rtc_alarm_pkg::BUS_READ;
            end
            else
            begin
              nxt_state.sda.oe = 1'b0;
              nxt_state.bus = rtc_alarm_pkg::BUS_WRITE;
            end
          end
        end
        rtc_alarm_pkg::BUS_READ:
        begin
          if (scl_fall)
          begin
            nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
            nxt_state.shift = {state_ff.shift[6:0], 1'b0};
            if (state_ff.bit_cnt == 4'h7)
            begin
              nxt_state.sda.oe = 1'b0;
              nxt_state.bus = rtc_alarm_pkg::BUS_READ_ACK;
            end
            else
              nxt_state.sda.oe = !state_ff.shift[6];
          end
        end
        rtc_alarm_pkg::BUS_READ_ACK:
        begin
          if (scl_rise)
            nxt_state.nack = i_sda;
          else if (scl_fall)
          begin
            if (state_ff.nack)
              nxt_state.bus = rtc_alarm_pkg::BUS_WAIT_STOP;
            else
            begin
              nxt_state.bit_cnt = 4'h0;
              nxt_state.shift = rd_byte;
              nxt_state.ptr = state_ff.ptr + 8'h01;
              nxt_state.sda.oe = !rd_byte[7];
              nxt_state.bus = rtc_alarm_pkg::BUS_READ;
            end
          end
        end
        rtc_alarm_pkg::BUS_WAIT_STOP: nxt_state.sda.oe = 1'b0;
        default: nxt_state.sda.oe = 1'b0;
      endcase
    end
    nxt_state.sda.out = 1'b0;

    // register writes win over the time chain in the same cycle
    if (do_write)
    begin
      case (state_ff.ptr)
        `OFS_CONTROL_ONE:
        begin
          nxt_state.test_sel = wr_data[`BIT_EXT_TICK_TEST_SELECT];
          nxt_state.halt = wr_data[`BIT_DIVIDER_HALT];
          nxt_state.permit = wr_data[`BIT_OVERRIDE_PERMIT];
          if (!wr_data[`BIT_OVERRIDE_PERMIT])
            nxt_state.override = 1'b0;
        end
        `OFS_CONTROL_STATUS_TWO:
        begin
          nxt_state.irq_style = wr_data[`BIT_COUNTDOWN_IRQ_STYLE];
          nxt_state.alarm_irq_enable = wr_data[`BIT_ALARM_IRQ_ENABLE];
          nxt_state.countdown_irq_enable = wr_data[`BIT_COUNTDOWN_IRQ_ENABLE];
          if (!wr_data[`BIT_ALARM_HIT_FLAG])
            nxt_state.hit_flag = 1'b0;
          if (!wr_data[`BIT_COUNTDOWN_FLAG])
            nxt_state.cd_flag = 1'b0;
        end
        `OFS_SECONDS_COUNT:
        begin
          nxt_state.oscillator_fail_flag = wr_data[`BIT_OSCILLATOR_FAIL_FLAG];
          nxt_state.sec = wr_data[6:0];
        end
        `OFS_MINUTES_COUNT: nxt_state.min = wr_data[6:0];
        `OFS_HOURS_COUNT: nxt_state.hour = wr_data[5:0];
        `OFS_DATE_COUNT: nxt_state.date = wr_data[5:0];
        `OFS_WEEKDAY_COUNT: nxt_state.wday = wr_data[2:0];
        `OFS_ALARM_MINUTE: nxt_state.al_min = wr_data;
        `OFS_ALARM_HOUR: nxt_state.al_hour = {wr_data[7], 1'b0, wr_data[5:0]};
        `OFS_ALARM_DATE: nxt_state.al_date = {wr_data[7], 1'b0, wr_data[5:0]};
        `OFS_ALARM_WEEKDAY: nxt_state.al_wday = {wr_data[7], 4'h0, wr_data[2:0]};
        default: nxt_state.oscillator_fail_flag = nxt_state.oscillator_fail_flag;
      endcase
    end

    // only the step into a match sets the flag; set beats a same-cycle clear
    if (match && !state_ff.match_q)
      nxt_state.hit_flag = 1'b1;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_ff <= '0;
      state_ff.permit <= `RST_OVERRIDE_PERMIT;
      state_ff.oscillator_fail_flag <= `RST_OSCILLATOR_FAIL_FLAG;
      state_ff.al_min <= 8'h80;
      state_ff.al_hour <= 8'h80;
      state_ff.al_date <= 8'h80;
      state_ff.al_wday <= 8'h80;
      state_ff.por <= 1'b1;
      state_ff.scl_q <= 1'b1;
      state_ff.sda_q <= 1'b1;
      state_ff.bus <= rtc_alarm_pkg::BUS_IDLE;
    end
    else
      state_ff <= nxt_state;
  end

  assign o_sqw = state_ff.square_wave_pin;
  assign o_sda = state_ff.sda;
  assign o_por_active = state_ff.por;
  assign o_override_active = state_ff.override;
  assign o_alarm_hit = state_ff.hit_flag;
  assign o_external_tick_mode = state_ff.test_sel;

endmodule : rtc_alarm_core

// ---- rtl/rtc_alarm_map.svh ----
// Purpose: register offsets, field positions, reset values and counts
// Assumes: included by the package users, bare name
// Notes: offsets are byte indices seen by the two-wire pointer
`ifndef RTC_ALARM_MAP_SVH
`define RTC_ALARM_MAP_SVH

`define OFS_CONTROL_ONE 8'h00
`define OFS_CONTROL_STATUS_TWO 8'h01
`define OFS_SECONDS_COUNT 8'h02
`define OFS_MINUTES_COUNT 8'h03
`define OFS_HOURS_COUNT 8'h04
`define OFS_DATE_COUNT 8'h05
`define OFS_WEEKDAY_COUNT 8'h06
`define OFS_ALARM_MINUTE 8'h09
`define OFS_ALARM_HOUR 8'h0a
`define OFS_ALARM_DATE 8'h0b
`define OFS_ALARM_WEEKDAY 8'h0c

// control one
`define BIT_EXT_TICK_TEST_SELECT 7
`define BIT_DIVIDER_HALT 5
`define BIT_OVERRIDE_PERMIT 3
// control status two
`define BIT_COUNTDOWN_IRQ_STYLE 4
`define BIT_ALARM_HIT_FLAG 3
`define BIT_COUNTDOWN_FLAG 2
`define BIT_ALARM_IRQ_ENABLE 1
`define BIT_COUNTDOWN_IRQ_ENABLE 0
// seconds, alarm registers
`define BIT_OSCILLATOR_FAIL_FLAG 7
`define BIT_ALARM_FIELD_DISABLE 7

`define RST_OVERRIDE_PERMIT 1'b1
`define RST_OSCILLATOR_FAIL_FLAG 1'b1
`define RST_ALARM_FIELD_DISABLE 1'b1

`define SLAVE_ADDR_7 7'h51
`define PRESCALE_FIRST_STEP 6'h1f

`define BCD_MAX_SECONDS 8'h59
`define BCD_MAX_MINUTES 8'h59
`define BCD_MAX_HOURS 8'h23
`define BCD_MAX_DATE 8'h31
`define BCD_MIN_DATE 8'h01
`define MAX_WEEKDAY 3'h6

`endif

// ---- rtl/rtc_alarm_pkg.sv ----
// Purpose: types shared by the alarm and serial port block
// Assumes: nothing is imported, users write rtc_alarm_pkg::name
// Notes: all block state lives in core_state_s
package rtc_alarm_pkg;

  typedef enum logic [3:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ACK,
    BUS_WRITE,
    BUS_READ,
    BUS_READ_ACK,
    BUS_WAIT_STOP
  } bus_state_e;

  // open-drain pin: out is the driven level, oe high while driving
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

  typedef struct packed {
    logic test_sel;
    logic halt;
    logic permit;
    logic irq_style;
    logic hit_flag;
    logic cd_flag;
    logic alarm_irq_enable;
    logic countdown_irq_enable;
    logic oscillator_fail_flag;
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [5:0] date;
    logic [2:0] wday;
    logic [7:0] al_min;
    logic [7:0] al_hour;
    logic [7:0] al_date;
    logic [7:0] al_wday;
    logic [5:0] prescale;
    logic sqw_q;
    logic match_q;
    logic por;
    logic override;
    logic scl_q;
    logic sda_q;
    bus_state_e bus;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic ptr_loaded;
    logic reading;
    logic nack;
    pin_drive_s sda;
    pin_drive_s square_wave_pin;
  } core_state_s;

endpackage : rtc_alarm_pkg

// ---- tb/rtc_alarm_core_assertions.sv ----
// Purpose: concurrent checks on the pins of the alarm and serial port core
// Assumes: one clock domain, reset asynchronous and active high
// Notes: bound to every instance of the core
`timescale 1ns/1ps

module rtc_alarm_core_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // inputs watched
  input wire logic i_osc_ready,
  input wire logic i_override_seq,
  input wire logic i_sqw_wave,
  input wire logic i_scl,
  // outputs watched
  input wire rtc_alarm_pkg::pin_drive_s o_sqw,
  input wire rtc_alarm_pkg::pin_drive_s o_sda,
  input wire logic o_por_active,
  input wire logic o_override_active,
  input wire logic o_alarm_hit,
  input wire logic o_external_tick_mode
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_por_drops;
    o_por_active ##1 !o_por_active;
  endsequence
  // the device may only start pulling while the clock line is low
  sequence s_scl_low;
    !i_scl;
  endsequence

  a_por_holds: assert property (o_por_active && !i_osc_ready && !i_override_seq
    |=> o_por_active) else $error("power-on reset left without cause");
  a_por_osc_exit: assert property (o_por_active && i_osc_ready |-> s_por_drops)
    else $error("power-on reset kept after oscillator ready");
  a_por_bus_quiet: assert property (o_por_active |-> !o_sda.oe)
    else $error("data line pulled during power-on reset");
  a_ovr_cause: assert property ($rose(o_override_active) |-> $past(i_override_seq))
    else $error("override entered without the pin sequence");
  a_drive_scl_low: assert property ($rose(o_sda.oe) |-> s_scl_low)
    else $error("data line pulled while clock high");
  a_drive_held: assert property (o_sda.oe && i_scl |=> o_sda.oe)
    else $error("data line released while clock high");
  a_test_pin_input: assert property (o_external_tick_mode && $past(o_external_tick_mode)
    |-> !o_sqw.oe) else $error("square-wave pin driven in test mode");
  a_wave_follows: assert property (!o_external_tick_mode && !$past(o_external_tick_mode)
    && !$past(i_sys_rst) |-> o_sqw.oe == !$past(i_sqw_wave))
    else $error("square wave not following its source");
  a_hit_clear_ack: assert property ($fell(o_alarm_hit) |-> $rose(o_sda.oe))
    else $error("alarm flag fell outside a register write");
endmodule : rtc_alarm_core_checker

bind rtc_alarm_core rtc_alarm_core_checker i_checker (.i_core_clk, .i_sys_rst,
  .i_osc_ready, .i_override_seq, .i_sqw_wave, .i_scl, .o_sqw, .o_sda, .o_por_active,
  .o_override_active, .o_alarm_hit, .o_external_tick_mode);

// ---- tb/i2c_host_model.sv ----
// Purpose: two-wire bus master model that drives SCL and pulls SDA
// Assumes: SDA is resolved outside with a pull-up; SCL idles high
// Notes: each SCL phase lasts 4 or 8 core clocks, above the 3-clock minimum
`timescale 1ns/1ps

module i2c_host_model (
  // clock
  input wire logic i_core_clk,
  // bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic ph();
    repeat (4) @(negedge i_core_clk);
  endtask : ph

  // also a repeated start when entered with SCL low
  task automatic start();
    o_sda_oe = 1'b0;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda_oe = 1'b1;
    ph();
    o_scl = 1'b0;
    ph();
  endtask : start

  task automatic stop();
    o_sda_oe = 1'b1;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda_oe = 1'b0;
    ph();
  endtask : stop

  // d of all ones releases SDA so the device can send; b9 low acknowledges
  task automatic bx(input logic [7:0] d, input logic b9, output logic [7:0] q, output logic r9);
    logic [8:0] v;
    logic [8:0] w;
    v = {d, b9};
    for (int i = 8; i >= 0; i--)
    begin
      o_sda_oe = !v[i];
      ph();
      o_scl = 1'b1;
      ph();
      w[i] = i_sda;
      o_scl = 1'b0;
      ph();
    end
    q = w[8:1];
    r9 = w[0];
  endtask : bx
endmodule : i2c_host_model

// ---- tb/rtc_alarm_test_serial_port_tb.sv ----
// Purpose: self-checking bench for the alarm, test tick and two-wire port
// Assumes: the host model owns SCL and pulls SDA; the bench owns the rest
// Notes: ticks and pin edges are issued by hand so every count is exact
`timescale 1ns/1ps

module rtc_alarm_test_serial_port_tb;
  logic clk;
  logic rst;
  logic tick;
  logic osc_ready;
  logic ovr_seq;
  logic sqw_wave;
  logic sqw_ext;
  logic scl;
  logic host_oe;
  logic por;
  logic ovr_act;
  logic hit;
  logic ext_mode;
  wire logic sda;
  wire logic sqw_pin;
  rtc_alarm_pkg::pin_drive_s sda_drive;
  rtc_alarm_pkg::pin_drive_s sqw_drive;
  int error_cnt = 0;
  int n_compared = 0;

  // both lines are open drain; SDA has a pull-up, the square-wave pin is held at sqw_ext
  assign sda = !(host_oe || sda_drive.oe);
  assign sqw_pin = sqw_ext && !sqw_drive.oe;

  rtc_alarm_core i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_tick_64hz(tick),
    .i_osc_ready(osc_ready), .i_override_seq(ovr_seq), .i_sqw_wave(sqw_wave),
    .i_sqw(sqw_pin), .o_sqw(sqw_drive), .i_scl(scl), .i_sda(sda), .o_sda(sda_drive),
    .o_por_active(por), .o_override_active(ovr_act), .o_alarm_hit(hit),
    .o_external_tick_mode(ext_mode));
  i2c_host_model i_host (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    logic [7:0] q;
    logic r;
    i_host.start();
    i_host.bx(8'ha2, 1'b1, q, r);
    chk(8'(r), 8'h00);
    i_host.bx(a, 1'b1, q, r);
    chk(8'(r), 8'h00);
    foreach (d[i])
    begin
      i_host.bx(d[i], 1'b1, q, r);
      chk(8'(r), 8'h00);
    end
    i_host.stop();
  endtask : wr

  // ptr low gives the simplified read from the current pointer
  task automatic rd(input logic ptr, input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e[$]);
    logic [7:0] q;
    logic r;
    i_host.start();
    // pointer byte, then a repeated start turns the bus round to reading
    if (ptr)
    begin
      i_host.bx(8'ha2, 1'b1, q, r);
      chk(8'(r), 8'h00);
      i_host.bx(a, 1'b1, q, r);
      chk(8'(r), 8'h00);
      i_host.start();
    end
    i_host.bx(8'ha3, 1'b1, q, r);
    chk(8'(r), 8'h00);
    foreach (e[i])
    begin
      i_host.bx(8'hff, i == e.size() - 1, q, r);
      chk(q & m, e[i]);
    end
    chk(8'(sda_drive.oe), 8'h00);
    i_host.stop();
  endtask : rd

  task automatic pulses(input int n, input logic ext);
    repeat (n)
    begin
      tick = !ext;
      sqw_ext = ext;
      wait_n(1);
      tick = 1'b0;
      sqw_ext = 1'b0;
      wait_n(3);
    end
  endtask : pulses

  task automatic seq_pulse();
    ovr_seq = 1'b1;
    wait_n(1);
    ovr_seq = 1'b0;
    wait_n(3);
  endtask : seq_pulse

  task automatic t_power_up();
    logic [7:0] q;
    logic r;
    wait_n(6);
    chk(8'(por), 8'h01);
    i_host.start();
    i_host.bx(8'ha2, 1'b1, q, r);
    i_host.stop();
    chk(8'(r), 8'h01);
    osc_ready = 1'b1;
    wait_n(3);
    chk(8'(por), 8'h00);
  endtask : t_power_up

  task automatic t_override();
    osc_ready = 1'b0;
    rst = 1'b1;
    wait_n(2);
    rst = 1'b0;
    seq_pulse();
    chk(8'({ovr_act, por}), 8'h02);
    wr(8'h00, '{8'h00});
    chk(8'(ovr_act), 8'h00);
    seq_pulse();
    chk(8'(ovr_act), 8'h00);
    wr(8'h00, '{8'h08});
    seq_pulse();
    chk(8'(ovr_act), 8'h01);
    wr(8'h00, '{8'h00});
  endtask : t_override

  task automatic t_regs();
    rd(1'b1, 8'h09, 8'hff, '{8'h80, 8'h80, 8'h80, 8'h80, 8'h00});
    wr(8'h09, '{8'hff, 8'hff, 8'hff, 8'hff, 8'h5a});
    wr(8'h09, '{});
    rd(1'b0, 8'h00, 8'hff, '{8'hff, 8'hbf, 8'hbf, 8'h87, 8'h00});
  endtask : t_regs

  task automatic t_addr();
    logic [7:0] bad [2];
    logic [7:0] q;
    logic r;
    // the reserved slave slots stay untouched
    bad = '{8'ha0, 8'ha4};
    foreach (bad[i])
    begin
      i_host.start();
      i_host.bx(bad[i], 1'b1, q, r);
      i_host.stop();
      chk(8'(r), 8'h01);
    end
  endtask : t_addr

  task automatic t_alarm();
    wr(8'h00, '{8'h20});
    sqw_wave = 1'b1;
    wait_n(3);
    chk(8'(sqw_drive.oe), 8'h00);
    sqw_wave = 1'b0;
    wait_n(3);
    chk(8'(sqw_drive.oe), 8'h01);
    wr(8'h02, '{8'h59, 8'h05, 8'h10, 8'h07, 8'h02});
    // hour compare disabled while its value mismatches
    wr(8'h09, '{8'h06, 8'h95, 8'h80, 8'h80});
    wr(8'h00, '{8'h00});
    pulses(31, 1'b0);
    chk(8'(hit), 8'h00);
    pulses(1, 1'b0);
    chk(8'(hit), 8'h01);
    wr(8'h01, '{8'h08});
    chk(8'(hit), 8'h01);
    rd(1'b1, 8'h01, 8'hff, '{8'h08});
    wr(8'h01, '{8'h00});
    chk(8'(hit), 8'h00);
    pulses(64, 1'b0);
    chk(8'(hit), 8'h00);
    rd(1'b1, 8'h02, 8'h7f, '{8'h01, 8'h06});
    // step the minutes away and let the running time walk back into the match
    wr(8'h02, '{8'h59, 8'h05});
    pulses(64, 1'b0);
    chk(8'(hit), 8'h01);
  endtask : t_alarm

  task automatic t_test_mode();
    wr(8'h00, '{8'h80});
    chk(8'({ext_mode, sqw_drive.oe}), 8'h02);
    wr(8'h00, '{8'ha0});
    pulses(40, 1'b1);
    wr(8'h00, '{8'h80});
    wr(8'h02, '{8'h00});
    pulses(31, 1'b1);
    pulses(5, 1'b0);
    rd(1'b1, 8'h02, 8'h7f, '{8'h00});
    pulses(1, 1'b1);
    rd(1'b1, 8'h02, 8'h7f, '{8'h01});
    pulses(64, 1'b1);
    rd(1'b1, 8'h02, 8'h7f, '{8'h02});
  endtask : t_test_mode

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // roughly five times the expected length of the run
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    rst = 1'b1;
    tick = 1'b0;
    osc_ready = 1'b0;
    ovr_seq = 1'b0;
    sqw_wave = 1'b0;
    sqw_ext = 1'b0;
    wait_n(2);
    rst = 1'b0;
    t_power_up();
    t_override();
    t_regs();
    t_addr();
    t_alarm();
    t_test_mode();
    give_verdict();
  end
endmodule : rtc_alarm_test_serial_port_tb
